// ---- src/anr_defs.svh ----
// constants for the next-page and negotiation-result register bank
// assumes 16-bit management registers addressed by word offset
`ifndef ANR_DEFS_SVH
`define ANR_DEFS_SVH

// register offsets within the auto-negotiation device
`define ANR_OFS_TX_MID        16'h0017
`define ANR_OFS_TX_HIGH       16'h0018
`define ANR_OFS_LP_LOW        16'h0019
`define ANR_OFS_LP_MID        16'h001A
`define ANR_OFS_LP_HIGH       16'h001B
`define ANR_OFS_RESULT        16'h0030

// reset values
`define ANR_RST_WORD          16'h0000
`define ANR_RST_RESULT        16'h0001

// partner low word fields
`define ANR_BIT_MORE_PAGES    15
`define ANR_BIT_PAGE_ACK      14
`define ANR_BIT_MSG_PAGE      13
`define ANR_BIT_SECOND_ACK    12
`define ANR_BIT_TOGGLE        11
`define ANR_CODE_HI           10
`define ANR_CODE_LO           0

// negotiation result fields
`define ANR_BIT_KR_FEC        4
`define ANR_BIT_KR            3
`define ANR_BIT_KX            1
`define ANR_BIT_SUPPORTED     0

// word slices of a 48-bit page
`define ANR_WORD_LOW          0
`define ANR_WORD_MID          1
`define ANR_WORD_HIGH         2
`define ANR_WORDS             3

`endif

// ---- src/anr_pkg.sv ----
// types shared by the next-page register bank
// assumes the constants header sits beside it
package anr_pkg;

  // register selected by a management address
  typedef enum logic [2:0] {
    ANR_SEL_NONE    = 3'b000,
    ANR_SEL_TX_MID  = 3'b001,
    ANR_SEL_TX_HIGH = 3'b010,
    ANR_SEL_LP_LOW  = 3'b011,
    ANR_SEL_LP_MID  = 3'b100,
    ANR_SEL_LP_HIGH = 3'b101,
    ANR_SEL_RESULT  = 3'b110
  } anr_sel_e;

  typedef logic [15:0] anr_word_t;

endpackage : anr_pkg

// ---- src/anr_partner_capture.sv ----
// holds the most recent extended next page received from the partner
// assumes pageValid is a one-cycle pulse with the page stable beside it
`timescale 1ns/100ps
`include "anr_defs.svh"

module anr_partner_capture
  import anr_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      pageValid,
  input  wire logic [3*WORD_W-1:0]       pageIn,
  output logic      [3*WORD_W-1:0]       pageHeld
);

  ////////////////////////////////////////////////////////////////////////
  // all three words load on the same edge, so a read never sees a mix
  genvar w;
  generate
    for (w = 0; w < `ANR_WORDS; w++) begin : g_word
      logic [WORD_W-1:0] word_ff;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          word_ff <= '0;
        end else if (pageValid) begin
          word_ff <= pageIn[w*WORD_W +: WORD_W];
        end
      end
      assign pageHeld[w*WORD_W +: WORD_W] = word_ff;
    end
  endgenerate

endmodule : anr_partner_capture

// ---- src/anr_tx_page.sv ----
// upper words of the outgoing extended next page and its toggle bit
// assumes pageSent pulses once per page handed to the link
`timescale 1ns/100ps
`include "anr_defs.svh"

module anr_tx_page
  import anr_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wrMid,
  input  wire logic              wrHigh,
  input  wire logic [WORD_W-1:0] wrData,
  input  wire logic              pageSent,
  output logic      [WORD_W-1:0] midWord,
  output logic      [WORD_W-1:0] highWord,
  output logic                   toggleBit
);

  logic [WORD_W-1:0] mid_ff;
  logic [WORD_W-1:0] high_ff;
  logic              toggle_ff;

  ////////////////////////////////////////////////////////////////////////
  // software-written words; toggle ignores any software value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mid_ff    <= '0;
      high_ff   <= '0;
      toggle_ff <= 1'b0;
    end else begin
      if (wrMid) mid_ff <= wrData;
      if (wrHigh) high_ff <= wrData;
      if (pageSent) toggle_ff <= ~toggle_ff;
    end
  end

  assign midWord   = mid_ff;
  assign highWord  = high_ff;
  assign toggleBit = toggle_ff;

endmodule : anr_tx_page

// ---- src/anr_next_page_regs.sv ----
// register bank for the extended next-page exchange and the
// negotiation result of a backplane auto-negotiation channel
// assumes a decoded management access port (one access per cycle),
// a negotiation engine that pulses on pages sent and received, and
// resolved-technology levels from the arbitration logic
//
// What this block does
// - 0x18 read-write, sends outgoing bits 47:32
// - low partner bit 15: more pages
// - low partner bit 14: acknowledge
// - low partner bit 13: message page
// - low partner bit 12: second acknowledge
// - low partner bit 11: toggle
// - low partner bits 10:0: code field
// - reading low word freezes upper two
// - 0x1A read-only, partner bits 31:16
// - 0x1B read-only, partner bits 47:32
// - result bit 4: KR with FEC
// - result bit 3: KR
// - result bit 1: KX
// - result bit 0 always one
// - 0x17 read-write, sends outgoing bits 31:16
// - hardware makes the transmitted toggle bit
`timescale 1ns/100ps
`include "anr_defs.svh"

module anr_next_page_regs
  import anr_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  // management access, already decoded to this device
  input  wire logic [15:0]         regAddr,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire logic [WORD_W-1:0]   regWrData,
  output logic      [WORD_W-1:0]   regRdData,
  output logic                     regRdValid,
  // outgoing page: low word comes from the first transmit register
  input  wire logic [WORD_W-1:0]   txLowWord,
  input  wire logic                txPageSent,
  output logic      [3*WORD_W-1:0] txNextPage,
  // incoming page from the partner
  input  wire logic                rxPageValid,
  input  wire logic [3*WORD_W-1:0] rxPage,
  // resolved technology from arbitration
  input  wire logic                resolvedKrFec,
  input  wire logic                resolvedKr,
  input  wire logic                resolvedKx
);

  ////////////////////////////////////////////////////////////////////////
  // the field positions assume 16-bit registers
  generate
    if (WORD_W != 16) begin : g_bad_width
      $error("anr_next_page_regs: WORD_W must be 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic anr_sel_e anrDecode(input logic [15:0] addr);
    anr_sel_e sel;
    sel = ANR_SEL_NONE;
    unique case (addr)
      `ANR_OFS_TX_MID:  sel = ANR_SEL_TX_MID;
      `ANR_OFS_TX_HIGH: sel = ANR_SEL_TX_HIGH;
      `ANR_OFS_LP_LOW:  sel = ANR_SEL_LP_LOW;
      `ANR_OFS_LP_MID:  sel = ANR_SEL_LP_MID;
      `ANR_OFS_LP_HIGH: sel = ANR_SEL_LP_HIGH;
      `ANR_OFS_RESULT:  sel = ANR_SEL_RESULT;
      default:          sel = ANR_SEL_NONE;
    endcase
    return sel;
  endfunction : anrDecode

  anr_sel_e              accessSel;
  logic                  wrTxMid;
  logic                  wrTxHigh;
  logic                  rdLpLow;
  logic [WORD_W-1:0]     txMidWord;
  logic [WORD_W-1:0]     txHighWord;
  logic                  txToggle;
  logic [3*WORD_W-1:0]   lpPage;
  logic [WORD_W-1:0]     lpLow;
  logic [WORD_W-1:0]     lpMid;
  logic [WORD_W-1:0]     lpHigh;
  logic [WORD_W-1:0]     shadowMid_ff;
  logic [WORD_W-1:0]     shadowHigh_ff;
  logic [WORD_W-1:0]     result_ff;
  logic [WORD_W-1:0]     nxt_result;
  logic [WORD_W-1:0]     rdMux;
  logic [WORD_W-1:0]     rdData_ff;
  logic                  rdValid_ff;
  logic [3*WORD_W-1:0]   txPage_ff;
  logic                  partnerMorePagesFlag;
  logic                  partnerPageAck;
  logic                  partnerMessagePageFlag;
  logic                  partnerSecondAck;
  logic                  partnerToggleBit;
  logic [10:0]           partnerCodeField;

  // writes to read-only or unmapped offsets are dropped silently
  assign accessSel = anrDecode(regAddr);
  assign wrTxMid   = regWrEn && (accessSel == ANR_SEL_TX_MID);
  assign wrTxHigh  = regWrEn && (accessSel == ANR_SEL_TX_HIGH);
  assign rdLpLow   = regRdEn && (accessSel == ANR_SEL_LP_LOW);

  ////////////////////////////////////////////////////////////////////////
  // outgoing page words and hardware toggle
  anr_tx_page #(
    .WORD_W    (WORD_W)
  ) u_tx_page (
    .clk       (clk),
    .nrst      (nrst),
    .wrMid     (wrTxMid),
    .wrHigh    (wrTxHigh),
    .wrData    (regWrData),
    .pageSent  (txPageSent),
    .midWord   (txMidWord),
    .highWord  (txHighWord),
    .toggleBit (txToggle)
  );

  // outgoing page, toggle replaced by the hardware copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txPage_ff <= '0;
    end else begin
      txPage_ff <= {txHighWord, txMidWord,
                    txLowWord[WORD_W-1:`ANR_BIT_TOGGLE+1],
                    txToggle,
                    txLowWord[`ANR_BIT_TOGGLE-1:0]};
    end
  end
  assign txNextPage = txPage_ff;

  ////////////////////////////////////////////////////////////////////////
  // partner page capture
  anr_partner_capture #(
    .WORD_W    (WORD_W)
  ) u_partner_capture (
    .clk       (clk),
    .nrst      (nrst),
    .pageValid (rxPageValid),
    .pageIn    (rxPage),
    .pageHeld  (lpPage)
  );

  assign lpLow  = lpPage[`ANR_WORD_LOW*WORD_W  +: WORD_W];
  assign lpMid  = lpPage[`ANR_WORD_MID*WORD_W  +: WORD_W];
  assign lpHigh = lpPage[`ANR_WORD_HIGH*WORD_W +: WORD_W];

  // named fields of the partner low word
  assign partnerMorePagesFlag   = lpLow[`ANR_BIT_MORE_PAGES];
  assign partnerPageAck         = lpLow[`ANR_BIT_PAGE_ACK];
  assign partnerMessagePageFlag = lpLow[`ANR_BIT_MSG_PAGE];
  assign partnerSecondAck       = lpLow[`ANR_BIT_SECOND_ACK];
  assign partnerToggleBit       = lpLow[`ANR_BIT_TOGGLE];
  assign partnerCodeField       =
    lpLow[`ANR_CODE_HI:`ANR_CODE_LO];

  ////////////////////////////////////////////////////////////////////////
  // upper words are frozen on a read of the low word, so a page that
  // lands between the three reads cannot tear the value software sees
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadowMid_ff  <= `ANR_RST_WORD;
      shadowHigh_ff <= `ANR_RST_WORD;
    end else if (rdLpLow) begin
      shadowMid_ff  <= lpMid;
      shadowHigh_ff <= lpHigh;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // negotiation result, resampled every cycle; bit 0 fixed at one
  always_comb begin
    nxt_result                     = `ANR_RST_RESULT;
    nxt_result[`ANR_BIT_KR_FEC]    = resolvedKrFec;
    nxt_result[`ANR_BIT_KR]        = resolvedKr;
    nxt_result[`ANR_BIT_KX]        = resolvedKx;
    nxt_result[`ANR_BIT_SUPPORTED] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_ff <= `ANR_RST_RESULT;
    end else begin
      result_ff <= nxt_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read selection; unmapped offsets answer zero
  always_comb begin
    rdMux = '0;
    unique case (accessSel)
      ANR_SEL_TX_MID:  rdMux = txMidWord;
      ANR_SEL_TX_HIGH: rdMux = txHighWord;
      ANR_SEL_LP_LOW:  rdMux = {partnerMorePagesFlag, partnerPageAck,
                                partnerMessagePageFlag, partnerSecondAck,
                                partnerToggleBit, partnerCodeField};
      ANR_SEL_LP_MID:  rdMux = shadowMid_ff;
      ANR_SEL_LP_HIGH: rdMux = shadowHigh_ff;
      ANR_SEL_RESULT:  rdMux = result_ff;
      ANR_SEL_NONE:    rdMux = '0;
    endcase
  end

  // read data registered, answered one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff  <= `ANR_RST_WORD;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= regRdEn;
      if (regRdEn) rdData_ff <= rdMux;
    end
  end

  assign regRdData  = rdData_ff;
  assign regRdValid = rdValid_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_TX_HIGH_WRITE: assert property (
    @(posedge clk) disable iff (!nrst)
    wrTxHigh |-> ##2 txNextPage[3*WORD_W-1:2*WORD_W] ==
                 $past(regWrData, 2))
    else $error("upper transmit word not sent as written");

  AST_TX_MID_WRITE: assert property (
    @(posedge clk) disable iff (!nrst)
    wrTxMid |-> ##2 txNextPage[2*WORD_W-1:WORD_W] ==
                $past(regWrData, 2))
    else $error("middle transmit word not sent as written");

  AST_TX_TOGGLE: assert property (
    @(posedge clk) disable iff (!nrst)
    txPageSent ##1 !txPageSent |=>
      txNextPage[`ANR_BIT_TOGGLE] != $past(txNextPage[`ANR_BIT_TOGGLE]))
    else $error("transmit toggle did not flip after a page");

  AST_LP_MORE: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> partnerMorePagesFlag ==
                    $past(rxPage[`ANR_BIT_MORE_PAGES]))
    else $error("partner more-pages flag wrong");

  AST_LP_ACK: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> partnerPageAck == $past(rxPage[`ANR_BIT_PAGE_ACK]))
    else $error("partner acknowledge wrong");

  AST_LP_MSG: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> partnerMessagePageFlag ==
                    $past(rxPage[`ANR_BIT_MSG_PAGE]))
    else $error("partner message-page flag wrong");

  AST_LP_ACK2: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> partnerSecondAck ==
                    $past(rxPage[`ANR_BIT_SECOND_ACK]))
    else $error("partner second acknowledge wrong");

  AST_LP_TOGGLE: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> partnerToggleBit == $past(rxPage[`ANR_BIT_TOGGLE]))
    else $error("partner toggle wrong");

  AST_LP_CODE: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid ##1 !rxPageValid
      ##1 (regRdEn && accessSel == ANR_SEL_LP_LOW && !rxPageValid)
      |=> regRdData[`ANR_CODE_HI:`ANR_CODE_LO] ==
          $past(rxPage[`ANR_CODE_HI:`ANR_CODE_LO], 3))
    else $error("partner code field read back wrong");

  AST_SNAPSHOT: assert property (
    @(posedge clk) disable iff (!nrst)
    rdLpLow ##1 (!rdLpLow)[*2] |-> shadowMid_ff == $past(lpMid, 2)
                                   && shadowHigh_ff == $past(lpHigh, 2))
    else $error("upper partner words not held after low read");

  AST_LP_MID_READ: assert property (
    @(posedge clk) disable iff (!nrst)
    rdLpLow ##1 !rdLpLow ##1 (regRdEn && accessSel == ANR_SEL_LP_MID)
      |=> regRdData == $past(lpMid, 3))
    else $error("partner middle word read wrong");

  AST_LP_HIGH_READ: assert property (
    @(posedge clk) disable iff (!nrst)
    rdLpLow ##1 !rdLpLow ##1 (regRdEn && accessSel == ANR_SEL_LP_HIGH)
      |=> regRdData == $past(lpHigh, 3))
    else $error("partner upper word read wrong");

  AST_RESULT_BITS: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 result_ff[`ANR_BIT_KR_FEC:`ANR_BIT_KX] ==
        {$past(resolvedKrFec), $past(resolvedKr), 1'b0,
         $past(resolvedKx)})
    else $error("negotiation result bits do not follow arbitration");

  AST_RESULT_SUPPORTED: assert property (
    @(posedge clk) disable iff (!nrst)
    (regRdEn && accessSel == ANR_SEL_RESULT)
      |=> regRdValid && regRdData[`ANR_BIT_SUPPORTED])
    else $error("supported bit read as zero");

  AST_LP_TOGETHER: assert property (
    @(posedge clk) disable iff (!nrst)
    rxPageValid |=> lpPage == $past(rxPage))
    else $error("partner words not captured together");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge clk) disable iff (!nrst)
    (regRdEn && accessSel == ANR_SEL_NONE)
      |=> regRdValid && regRdData == '0)
    else $error("unmapped read did not return zero");

  AST_TX_TOGGLE_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    !txPageSent |-> ##2 $stable(txNextPage[`ANR_BIT_TOGGLE]))
    else $error("transmit toggle moved without a page sent");

  AST_TX_LOW_PASS: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 {txNextPage[WORD_W-1:`ANR_BIT_TOGGLE+1],
         txNextPage[`ANR_BIT_TOGGLE-1:0]} ==
        $past({txLowWord[WORD_W-1:`ANR_BIT_TOGGLE+1],
               txLowWord[`ANR_BIT_TOGGLE-1:0]}))
    else $error("transmit low word not passed through");

  AST_RD_VALID: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 regRdValid == $past(regRdEn))
    else $error("read valid is not a one-cycle answer");

endmodule : anr_next_page_regs

// ---- dv/anr_link_partner.sv ----
// far-side negotiation engine: hands pages in and takes pages out
// assumes the bench pulses sendGo/takeGo for one cycle each
`timescale 1ns/100ps

module anr_link_partner (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sendGo,
  input  wire logic [47:0] sendPage,
  input  wire logic [3:0]  sendDelay,
  input  wire logic        takeGo,
  output logic             pageValid,
  output logic      [47:0] pageOut,
  output logic             pageTaken
);
  logic        pending_ff;
  logic [3:0]  waitCnt_ff;
  logic [47:0] held_ff;

  //////////////////////////////////////////////////////////////////////
  // page bus churns outside the valid cycle so stale data never looks
  // right by chance; the delay lets the partner answer slowly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending_ff <= 1'b0;
      waitCnt_ff <= 4'h0;
      held_ff    <= 48'h0;
      pageValid  <= 1'b0;
      pageOut    <= 48'hFFFF_FFFF_FFFF;
      pageTaken  <= 1'b0;
    end else begin
      pageValid <= 1'b0;
      pageTaken <= takeGo; // one page accepted per pulse
      pageOut   <= ~pageOut;
      if (sendGo) begin
        pending_ff <= 1'b1;
        waitCnt_ff <= sendDelay;
        held_ff    <= sendPage;
      end else if (pending_ff && waitCnt_ff == 4'h0) begin
        pageValid  <= 1'b1; // whole 48-bit page in one cycle
        pageOut    <= held_ff;
        pending_ff <= 1'b0;
      end else if (pending_ff) begin
        waitCnt_ff <= waitCnt_ff - 4'h1;
      end
    end
  end
endmodule : anr_link_partner

// ---- dv/tb.sv ----
// self-checking bench for the next-page register bank
// assumes the partner model on the page ports, one access per strobe
`timescale 1ns/100ps

module tb;
  import anr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0;
  logic [15:0] regAddr = 16'h0, regWrData = 16'h0, txLowWord = 16'h0;
  logic regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
  logic [15:0] regRdData;
  logic [47:0] txNextPage, rxPage, sendPage = 48'h0;
  logic txPageSent, rxPageValid, sendGo = 1'b0, takeGo = 1'b0;
  logic [3:0] sendDelay = 4'h0;
  logic kf = 1'b0, kr = 1'b0, kx = 1'b0, expTog = 1'b0;
  logic [15:0] rd;
  int fail_count = 0, total_checks = 0, cycles = 0;

  //////////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;

  anr_next_page_regs dut_u (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .txLowWord(txLowWord), .txPageSent(txPageSent),
    .txNextPage(txNextPage), .rxPageValid(rxPageValid), .rxPage(rxPage),
    .resolvedKrFec(kf), .resolvedKr(kr), .resolvedKx(kx));

  anr_link_partner partner_u (.clk(clk), .nrst(nrst), .sendGo(sendGo),
    .sendPage(sendPage), .sendDelay(sendDelay), .takeGo(takeGo),
    .pageValid(rxPageValid), .pageOut(rxPage), .pageTaken(txPageSent));

  //////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // hang guard, well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("[ERR] timeout exp done seen hang");
      results();
    end
  end

  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  // answer stands one cycle after the strobe edge, so look then
  task automatic rdReg(logic [15:0] a);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk("rdValid", regRdValid, 1'b1);
    rd = regRdData;
  endtask : rdReg

  task automatic sendRx(logic [47:0] p, logic [3:0] lat);
    @(posedge clk);
    sendGo    <= 1'b1;
    sendPage  <= p;
    sendDelay <= lat;
    @(posedge clk);
    sendGo <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rxPageValid === 1'b1) break;
    end
  endtask : sendRx

  task automatic chkTx(logic [31:0] hi);
    repeat (3) @(posedge clk);
    #1;
    chk("txPage", txNextPage, {hi, txLowWord[15:12], expTog,
      txLowWord[10:0]});
  endtask : chkTx

  //////////////////////////////////////////////////////////////////////
  // every register at its reset value, unmapped reads give zero
  task automatic t_reset();
    logic [15:0] addrs[7] = '{16'h17, 16'h18, 16'h19, 16'h1A, 16'h1B,
                              16'h30, 16'h31};
    logic [15:0] exps[7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                             16'h0001, 16'h0};
    for (int i = 0; i < 7; i++) begin
      rdReg(addrs[i]);
      chk("resetVal", rd, exps[i]);
    end
    $display("reset test done");
  endtask : t_reset

  // transmit words, hardware toggle, read-only places refuse writes
  task automatic t_tx();
    txLowWord <= 16'h0800;
    wr(16'h17, 16'hA5C3);
    wr(16'h18, 16'hFFFF);
    chkTx(32'hFFFF_A5C3);
    rdReg(16'h18);
    chk("txHigh", rd, 16'hFFFF);
    rdReg(16'h17);
    chk("txMid", rd, 16'hA5C3);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      takeGo <= 1'b1;
      @(posedge clk);
      takeGo <= 1'b0;
      expTog = ~expTog;
      chkTx(32'hFFFF_A5C3);
    end
    wr(16'h19, 16'h1234);
    wr(16'h1A, 16'h1234);
    wr(16'h1B, 16'h1234);
    wr(16'h30, 16'hFFFF);
    rdReg(16'h19);
    chk("roLow", rd, 16'h0);
    rdReg(16'h1A);
    chk("roMid", rd, 16'h0);
    rdReg(16'h1B);
    chk("roHigh", rd, 16'h0);
    rdReg(16'h30);
    chk("roRes", rd, 16'h0001);
    $display("transmit test done");
  endtask : t_tx

  task automatic chkLow(logic [15:0] p);
    rdReg(16'h19);
    chk("moreFlag", rd[15], p[15]);
    chk("pageAck", rd[14], p[14]);
    chk("msgFlag", rd[13], p[13]);
    chk("ack2", rd[12], p[12]);
    chk("toggle", rd[11], p[11]);
    chk("code", rd[10:0], p[10:0]);
  endtask : chkLow

  // upper words freeze at the low-word read, then move together
  task automatic t_rx();
    logic [47:0] p1 = 48'h1357_C3A5_AAAA, p2 = 48'hECA8_3C5A_5555;
    sendRx(p1, 4'h0);
    chkLow(p1[15:0]);
    rdReg(16'h1A);
    chk("mid1", rd, p1[31:16]);
    sendRx(p2, 4'h3);
    rdReg(16'h1A);
    chk("midFrozen", rd, p1[31:16]);
    rdReg(16'h1B);
    chk("highFrozen", rd, p1[47:32]);
    chkLow(p2[15:0]);
    rdReg(16'h1B);
    chk("high2", rd, p2[47:32]);
    rdReg(16'h1A);
    chk("mid2", rd, p2[31:16]);
    $display("partner page test done");
  endtask : t_rx

  // all eight combinations of resolved technology
  task automatic t_result();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {kf, kr, kx} <= i[2:0];
      @(posedge clk);
      rdReg(16'h30);
      chk("result", rd, {11'h0, i[2:1], 1'b0, i[0], 1'b1});
    end
    $display("result test done");
  endtask : t_result

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk("rstTx", txNextPage, 48'h0);
    chk("rstValid", regRdValid, 1'b0);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_result();
    results();
  end
endmodule : tb
